// ===== include/llsi_pkg.sv
// Shared constants for the lift door limit and speed input block.
// Assumes one 100 MHz clock and a word-wide AHB-Lite register port.
package llsi_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ---------------------------------------------------------------
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam logic [3:0]  REG_CMD    = 4'h8;
    localparam logic [3:0]  REG_CUTS   = 4'hC;

    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int          CTRL_W        = 5;
    localparam int          CTRL_ZSPD     = 0;
    localparam int          CTRL_INV_LSB  = 1;
    localparam logic [4:0]  CTRL_RST      = 5'h00;
    localparam int          CUT_W         = 16;

    // ---------------------------------------------------------------
    // Pin vector layout: door limits, decel and correction switches
    // ---------------------------------------------------------------
    localparam int          DOOR_N        = 4;
    localparam int          PIN_NORM_LSB  = 0;
    localparam int          PIN_INV_LSB   = 4;
    localparam int          PIN_CLOSE_INV_B = 8;
    localparam int          PIN_MID_BOT   = 9;
    localparam int          PIN_MID_TOP   = 10;
    localparam int          PIN_CORR_BOT  = 11;
    localparam int          PIN_CORR_TOP  = 12;
    localparam int          PIN_ZSPD      = 13;
    localparam int          PIN_N         = 14;
    // Idle levels: active-low switches rest high, others rest low.
    localparam logic [13:0] PIN_RST       = 14'h1E0F;

    // ---------------------------------------------------------------
    // Motion states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_UP,
        ST_DOWN,
        ST_HOLD_UP,
        ST_HOLD_DOWN
    } llsi_state_e;

endpackage : llsi_pkg

// ===== rtl/llsi_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes the pins are slow levels; no pulse is narrower than a cycle.
`timescale 1ns/1ps
module llsi_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1   <= RST;
            pin_sync <= RST;
        end else begin
            stage1   <= pin_in;
            pin_sync <= stage1;
        end
    end

endmodule : llsi_sync

// ===== rtl/llsi_limit_sel.sv
// Polarity selection for one fireman door limit.
// Assumes both inputs are already synchronised to hclk.
`timescale 1ns/1ps
module llsi_limit_sel (
    input  wire logic norm_level,
    input  wire logic inv_level,
    input  wire logic use_inv,
    output logic      reached
);

    // Normal form reaches at 0V, inverted form reaches at +24V.
    assign reached = use_inv ? inv_level : ~norm_level;

endmodule : llsi_limit_sel

// ===== rtl/llsi_top.sv
// Door limit, speed-limit and zero-speed input conditioning for a lift.
// Assumes pins are asynchronous and the motion sequencer shares hclk.
`timescale 1ns/1ps
module llsi_top
    import llsi_pkg::*;
#(
    parameter int NUM_DOORS = DOOR_N
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave port.
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Fireman door limits, normal form (0V reached).
    input  wire logic                 fire_door_open_limit_side_a,
    input  wire logic                 fire_door_closed_limit_side_a,
    input  wire logic                 fire_door_open_limit_side_b,
    input  wire logic                 fire_door_closed_limit_side_b,
    // Fireman door limits, inverted form (+24V reached).
    input  wire logic                 fire_door_open_limit_inv_side_a,
    input  wire logic                 fire_door_close_limit_inv_side_a,
    input  wire logic                 fire_door_open_limit_inv_side_b,
    input  wire logic                 fire_door_close_limit_inv_side_b,
    input  wire logic                 close_limit_inverted_side_b,
    // Shaft switches, all active low; drive zero-speed feedback, high while running.
    input  wire logic                 mid_speed_bottom_limit_n,
    input  wire logic                 mid_speed_top_limit_n,
    input  wire logic                 correction_bottom_n,
    input  wire logic                 correction_top_n,
    input  wire logic                 drive_zero_speed_feedback,
    // Requests from the motion sequencer.
    input  wire logic                 req_up,
    input  wire logic                 req_down,
    input  wire logic                 req_high,
    input  wire logic                 req_mid,
    input  wire logic                 req_low,
    // Commands to the drive inverter.
    output logic                      cmd_up,
    output logic                      cmd_down,
    output logic                      cmd_high,
    output logic                      cmd_mid,
    output logic                      cmd_low,
    // Conditioned limit flags to the sequencer.
    output logic [NUM_DOORS-1:0]      fire_limit_reached,
    output logic                      close_limit_b_reached,
    output logic                      drive_stopped
);

    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s;

    // Gather the pins in package order.
    assign pin_raw = {drive_zero_speed_feedback,
                      correction_top_n,
                      correction_bottom_n,
                      mid_speed_top_limit_n,
                      mid_speed_bottom_limit_n,
                      close_limit_inverted_side_b,
                      fire_door_close_limit_inv_side_b,
                      fire_door_open_limit_inv_side_b,
                      fire_door_close_limit_inv_side_a,
                      fire_door_open_limit_inv_side_a,
                      fire_door_closed_limit_side_b,
                      fire_door_open_limit_side_b,
                      fire_door_closed_limit_side_a,
                      fire_door_open_limit_side_a};

    // Two flops before any logic reads a pin.
    llsi_sync #(
        .W   (PIN_N),
        .RST (PIN_RST)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   (pin_raw),
        .pin_sync (pin_s)
    );

    // ---------------------------------------------------------------
    // Registers written by software
    // ---------------------------------------------------------------

    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [CUT_W-1:0]  cut_count;
    logic [CUT_W-1:0]  next_cut_count;
    wire               zspd_enable = ctrl[CTRL_ZSPD];
    wire [NUM_DOORS-1:0] use_inv  = ctrl[CTRL_INV_LSB +: NUM_DOORS];

    // ---------------------------------------------------------------
    // Input conditioning
    // ---------------------------------------------------------------

    logic [NUM_DOORS-1:0] door_reached;

    // One polarity selector per fireman door limit.
    for (genvar i = 0; i < NUM_DOORS; i++) begin : g_door
        llsi_limit_sel u_sel (
            .norm_level (pin_s[PIN_NORM_LSB + i]),
            .inv_level  (pin_s[PIN_INV_LSB + i]),
            .use_inv    (use_inv[i]),
            .reached    (door_reached[i])
        );
    end

    // Shaft switches assert at 0V; the zero-speed level is high while running.
    wire close_b_hit  = pin_s[PIN_CLOSE_INV_B];
    wire mid_bot_hit  = ~pin_s[PIN_MID_BOT];
    wire mid_top_hit  = ~pin_s[PIN_MID_TOP];
    wire corr_bot_hit = ~pin_s[PIN_CORR_BOT];
    wire corr_top_hit = ~pin_s[PIN_CORR_TOP];
    wire drive_run    = pin_s[PIN_ZSPD];

    // ---------------------------------------------------------------
    // Motion state machine
    // ---------------------------------------------------------------

    llsi_state_e state;
    llsi_state_e next_state;

    wire want_up   = req_up & ~req_down;
    wire want_down = req_down & ~req_up;

    // A dropped request either stops at once or waits for zero speed.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (want_up) begin
                    next_state = ST_UP;
                end else if (want_down) begin
                    next_state = ST_DOWN;
                end
            end
            ST_UP: begin
                if (!want_up) begin
                    next_state = zspd_enable ? ST_HOLD_UP : ST_IDLE;
                end
            end
            ST_DOWN: begin
                if (!want_down) begin
                    next_state = zspd_enable ? ST_HOLD_DOWN : ST_IDLE;
                end
            end
            ST_HOLD_UP, ST_HOLD_DOWN: begin
                if (!drive_run || !zspd_enable) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // Speed and direction commands
    // ---------------------------------------------------------------

    wire running     = (next_state == ST_UP) | (next_state == ST_DOWN);
    wire high_cut    = corr_bot_hit | corr_top_hit;
    wire mid_cut     = mid_bot_hit | mid_top_hit;

    // Speeds drop with the run; direction may outlast them while held.
    wire next_cmd_high = running & req_high & ~high_cut;
    wire next_cmd_mid  = running & req_mid & ~mid_cut;
    wire next_cmd_low  = running & req_low;
    wire next_cmd_up   = (next_state == ST_UP) | (next_state == ST_HOLD_UP);
    wire next_cmd_down = (next_state == ST_DOWN) | (next_state == ST_HOLD_DOWN);

    // Count each cycle in which a requested speed is being cut.
    wire cut_event = running & ((req_high & high_cut) | (req_mid & mid_cut));

    // Command and flag outputs are all registered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_up                <= 1'b0;
            cmd_down              <= 1'b0;
            cmd_high              <= 1'b0;
            cmd_mid               <= 1'b0;
            cmd_low               <= 1'b0;
            fire_limit_reached    <= '0;
            close_limit_b_reached <= 1'b0;
            drive_stopped         <= 1'b1;
        end else begin
            cmd_up                <= next_cmd_up;
            cmd_down              <= next_cmd_down;
            cmd_high              <= next_cmd_high;
            cmd_mid               <= next_cmd_mid;
            cmd_low               <= next_cmd_low;
            fire_limit_reached    <= door_reached;
            close_limit_b_reached <= close_b_hit;
            drive_stopped         <= ~drive_run;
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite address and data phase
    // ---------------------------------------------------------------

    logic              wr_pending;
    logic [ADDR_W-1:0] wr_addr;

    // An address phase is taken when selected, NONSEQ or SEQ, and ready.
    wire               take     = hsel & htrans[1] & hready;
    wire [ADDR_W-1:0]  a_addr   = haddr[ADDR_W-1:0];
    wire               take_rd  = take & ~hwrite;
    wire               take_wr  = take & hwrite;
    wire               wr_ctrl  = wr_pending & (wr_addr == REG_CTRL);
    wire               wr_cuts  = wr_pending & (wr_addr == REG_CUTS);

    // A pending write lands at the end of its data phase.
    assign next_ctrl = wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl;

    // Any write to the counter clears it; a new cut in that cycle still counts.
    always_comb begin
        next_cut_count = cut_count;
        if (wr_cuts) begin
            next_cut_count = '0;
        end
        if (cut_event && (next_cut_count != '1)) begin
            next_cut_count = next_cut_count + 1'b1;
        end
    end

    // Read sources; status and commands reflect the block's own state.
    wire [31:0] rd_ctrl   = {{(32-CTRL_W){1'b0}}, next_ctrl};
    wire [31:0] rd_status = {{(32-NUM_DOORS-6){1'b0}},
                             drive_run, corr_top_hit, corr_bot_hit,
                             mid_top_hit, mid_bot_hit, close_b_hit,
                             door_reached};
    wire [31:0] rd_cmd    = {{24{1'b0}}, state,
                             cmd_low, cmd_mid, cmd_high, cmd_down, cmd_up};
    wire [31:0] rd_cuts   = {{(32-CUT_W){1'b0}}, next_cut_count};

    // Only haddr[3:0] is decoded, so higher addresses alias; unused low offsets read as zero and ignore writes.
    wire [31:0] rd_mux = (a_addr == REG_CTRL)   ? rd_ctrl   :
                         (a_addr == REG_STATUS) ? rd_status :
                         (a_addr == REG_CMD)    ? rd_cmd    :
                         (a_addr == REG_CUTS)   ? rd_cuts   : 32'h0000_0000;

    // Bus-side flops: zero-wait slave with an always OKAY answer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0000_0000;
            wr_pending <= 1'b0;
            wr_addr    <= '0;
        end else begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pending <= take_wr;
            if (take_wr) begin
                wr_addr <= a_addr;
            end
            if (take_rd) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Software registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= CTRL_RST;
            cut_count <= '0;
        end else begin
            ctrl      <= next_ctrl;
            cut_count <= next_cut_count;
        end
    end

endmodule : llsi_top

// ===== dv/llsi_props.sv
// Concurrent checks on the ports of the lift input block.
// Assumes binding to llsi_top; pins reach the logic through two flops.
`timescale 1ns/1ps
module llsi_props
    import llsi_pkg::*;
#(
    parameter int NUM_DOORS = DOOR_N
) (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 fire_door_open_limit_side_a,
    input wire logic                 fire_door_closed_limit_side_a,
    input wire logic                 fire_door_open_limit_side_b,
    input wire logic                 fire_door_closed_limit_side_b,
    input wire logic                 fire_door_open_limit_inv_side_a,
    input wire logic                 fire_door_close_limit_inv_side_a,
    input wire logic                 fire_door_open_limit_inv_side_b,
    input wire logic                 fire_door_close_limit_inv_side_b,
    input wire logic                 close_limit_inverted_side_b,
    input wire logic                 mid_speed_bottom_limit_n,
    input wire logic                 mid_speed_top_limit_n,
    input wire logic                 correction_bottom_n,
    input wire logic                 correction_top_n,
    input wire logic                 drive_zero_speed_feedback,
    input wire logic                 req_up,
    input wire logic                 req_down,
    input wire logic                 cmd_up,
    input wire logic                 cmd_down,
    input wire logic                 cmd_high,
    input wire logic                 cmd_mid,
    input wire logic                 cmd_low,
    input wire logic [NUM_DOORS-1:0] fire_limit_reached,
    input wire logic                 close_limit_b_reached,
    input wire logic                 drive_stopped
);
    // ----------------------------------------------------------------
    // Helper logic and checks
    // ----------------------------------------------------------------
    logic [2:0] age;
    logic       wr_ctrl;
    logic [4:0] ctrl;
    wire        ok  = (age == 3'h4);
    wire  [3:0] nrm = {fire_door_closed_limit_side_b, fire_door_open_limit_side_b,
                       fire_door_closed_limit_side_a, fire_door_open_limit_side_a};
    wire  [3:0] inv = {fire_door_close_limit_inv_side_b, fire_door_open_limit_inv_side_b,
                       fire_door_close_limit_inv_side_a, fire_door_open_limit_inv_side_a};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Counts the first four edges since reset and shadows the control word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age     <= 3'h0;
            wr_ctrl <= 1'b0;
            ctrl    <= 5'h00;
        end else begin
            if (age != 3'h4) age <= age + 3'h1;
            if (hready) wr_ctrl <= hsel && htrans[1] && hwrite && (haddr[3:0] == REG_CTRL);
            if (wr_ctrl && hready) ctrl <= hwdata[4:0];
        end
    end
    a_high_cut_bot: assert property (ok && !$past(correction_bottom_n, 3) |-> !cmd_high)
        else $error("high speed on at bottom correction");
    a_high_cut_top: assert property (ok && !$past(correction_top_n, 3) |-> !cmd_high)
        else $error("high speed on at top correction");
    a_mid_cut_bot: assert property (ok && !$past(mid_speed_bottom_limit_n, 3) |-> !cmd_mid)
        else $error("mid speed on at bottom limit");
    a_mid_cut_top: assert property (ok && !$past(mid_speed_top_limit_n, 3) |-> !cmd_mid)
        else $error("mid speed on at top limit");
    a_drop_together: assert property (ok && !$past(ctrl[0]) && !$past(req_up)
        && !$past(req_down) |-> !(cmd_up || cmd_down || cmd_high || cmd_mid || cmd_low))
        else $error("commands not dropped together");
    a_hold_dir: assert property (ok && $past(ctrl[0]) && $past(cmd_up)
        && $past(drive_zero_speed_feedback, 3) |-> cmd_up)
        else $error("up dropped while running");
    a_door_flags: assert property (ok |-> fire_limit_reached == (($past(ctrl[4:1]) & $past(inv, 3))
        | (~$past(ctrl[4:1]) & ~$past(nrm, 3))))
        else $error("door limit flag wrong");
    a_close_b_flag: assert property (ok |-> close_limit_b_reached
        == $past(close_limit_inverted_side_b, 3))
        else $error("side b close flag wrong");
    a_stopped_flag: assert property (ok |-> drive_stopped
        == !$past(drive_zero_speed_feedback, 3))
        else $error("drive stopped flag wrong");
    c_high_run: cover property (ok && cmd_high);
    c_hold_up: cover property (ok && $past(ctrl[0]) && cmd_up && !$past(req_up));
    c_stop_seen: cover property (ok && $rose(drive_stopped));
endmodule : llsi_props

bind llsi_top llsi_props #(.NUM_DOORS(NUM_DOORS)) u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .fire_door_open_limit_side_a, .fire_door_closed_limit_side_a,
    .fire_door_open_limit_side_b, .fire_door_closed_limit_side_b,
    .fire_door_open_limit_inv_side_a, .fire_door_close_limit_inv_side_a,
    .fire_door_open_limit_inv_side_b, .fire_door_close_limit_inv_side_b,
    .close_limit_inverted_side_b, .mid_speed_bottom_limit_n, .mid_speed_top_limit_n,
    .correction_bottom_n, .correction_top_n, .drive_zero_speed_feedback, .req_up, .req_down,
    .cmd_up, .cmd_down, .cmd_high, .cmd_mid, .cmd_low, .fire_limit_reached,
    .close_limit_b_reached, .drive_stopped
);

// ===== dv/llsi_shaft_model.sv
// Behavioural shaft switches and drive inverter facing the lift input block.
// Assumes the bench sets the switches and the run-down time.
`timescale 1ns/1ps
module llsi_shaft_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] reached,
    input  wire logic [3:0] wire_inv,
    input  wire logic [3:0] shaft_on,
    input  wire logic [7:0] rundown,
    input  wire logic       running,
    output logic      [3:0] lim_n,
    output logic      [3:0] lim_inv,
    output logic            close_b_inv,
    output logic      [3:0] shaft_n,
    output logic            zero_speed
);
    logic [7:0] cnt;
    // Wired contacts show the limit; unwired ones rest at their idle level.
    assign lim_n       = ~(reached & ~wire_inv);
    assign lim_inv     = reached & wire_inv;
    assign close_b_inv = reached[3];
    assign shaft_n     = ~shaft_on;
    // The drive reports running while driven and runs on for the run-down time.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_speed <= 1'b0;
            cnt        <= 8'h00;
        end else if (running) begin
            zero_speed <= 1'b1;
            cnt        <= rundown;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else begin
            zero_speed <= 1'b0;
        end
    end
endmodule : llsi_shaft_model

// ===== dv/llsi_top_tb.sv
// Self-checking bench for the lift door limit and speed input block.
// Assumes the shaft model on the pins and a single-slave AHB-Lite bus.
`timescale 1ns/1ps
module llsi_top_tb
    import llsi_pkg::*;
;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [4:0]  req     = 5'h00;
    logic [3:0]  reached = 4'h0;
    logic [3:0]  inv_w   = 4'h0;
    logic [3:0]  shaft   = 4'h0;
    logic [31:0] seed    = 32'h0000_3c79;
    int          n_fail  = 0;
    int          n_tests = 0;
    wire         hreadyout, hresp, close_b, stopped, cb_inv, zspd;
    wire  [31:0] hrdata;
    wire  [4:0]  cmd;
    wire  [3:0]  flags, lim_n, lim_inv, shaft_n;
    always #5 hclk = ~hclk;
    // Device and far-side model.
    llsi_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .fire_door_open_limit_side_a(lim_n[0]), .fire_door_closed_limit_side_a(lim_n[1]),
        .fire_door_open_limit_side_b(lim_n[2]), .fire_door_closed_limit_side_b(lim_n[3]),
        .fire_door_open_limit_inv_side_a(lim_inv[0]), .fire_door_close_limit_inv_side_a(lim_inv[1]),
        .fire_door_open_limit_inv_side_b(lim_inv[2]), .fire_door_close_limit_inv_side_b(lim_inv[3]),
        .close_limit_inverted_side_b(cb_inv), .mid_speed_bottom_limit_n(shaft_n[0]),
        .mid_speed_top_limit_n(shaft_n[1]), .correction_bottom_n(shaft_n[2]),
        .correction_top_n(shaft_n[3]), .drive_zero_speed_feedback(zspd),
        .req_up(req[0]), .req_down(req[1]), .req_high(req[2]), .req_mid(req[3]), .req_low(req[4]),
        .cmd_up(cmd[0]), .cmd_down(cmd[1]), .cmd_high(cmd[2]), .cmd_mid(cmd[3]), .cmd_low(cmd[4]),
        .fire_limit_reached(flags), .close_limit_b_reached(close_b), .drive_stopped(stopped));
    llsi_shaft_model u_far (.hclk, .hresetn, .reached, .wire_inv(inv_w), .shaft_on(shaft),
        .rundown(8'h14), .running((cmd[0] | cmd[1]) & (cmd[2] | cmd[3] | cmd[4])),
        .lim_n, .lim_inv, .close_b_inv(cb_inv), .shaft_n, .zero_speed(zspd));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Expected commands {low, mid, high, down, up} for a run with switches sw.
    function automatic logic [4:0] exp_cmd(input logic [3:0] sw, input logic dn);
        return {1'b1, ~(sw[0] | sw[1]), ~(sw[2] | sw[3]), dn, ~dn};
    endfunction : exp_cmd
    task automatic rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : rdy
    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin : main
        logic [31:0] r, q;
        logic [3:0]  s, iv;
        logic [4:0]  e;
        logic        d;
        int          n;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(32'({stopped, cmd}), 32'h0000_0020, "reset outputs");
        bus(1'b0, 32'(REG_CTRL), 32'h0, q);
        chk(q, 32'h0000_0000, "ctrl reset");
        bus(1'b0, 32'(REG_STATUS), 32'h0, q);
        chk(q, 32'h0000_0000, "status idle");
        // Door limits and speed cuts, corners first then random; each run ends in a stop.
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            s = (i < 2) ? {4{i[0]}} : r[3:0];
            iv = (i < 2) ? {4{i[0]}} : r[7:4];
            d = r[8];
            reached <= s;
            inv_w <= iv;
            shaft <= (i < 2) ? {4{i[0]}} : r[12:9];
            bus(1'b1, 32'(REG_CTRL), 32'({iv, 1'b0}), q);
            repeat (4) @(posedge hclk);
            @(negedge hclk);
            chk(32'(flags), 32'(s), "door flags");
            chk(32'(close_b), 32'(s[3]), "side b close");
            bus(1'b0, 32'(REG_STATUS), 32'h0, q);
            chk(q & 32'h0000_001f, 32'({s[3], s}), "status doors");
            chk(32'(q[8:5]), 32'(shaft), "status shaft");
            req <= {3'h7, d, ~d};
            @(posedge hclk);
            @(negedge hclk);
            e = exp_cmd(shaft, d);
            chk(32'(cmd), 32'(e), "speed cut");
            bus(1'b0, 32'(REG_CMD), 32'h0, q);
            chk(32'(q[7:0]), 32'({d ? 3'h2 : 3'h1, e}), "cmd register");
            req <= 5'h00;
            @(posedge hclk);
            @(negedge hclk);
            chk(32'(cmd), 32'h0000_0000, "stop together");
            chk(32'({hresp, hreadyout}), 32'h1, "bus ok");
        end
        $display("test speeds done");
        // Zero-speed hold until the drive has stopped.
        shaft <= 4'h0;
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0001, q);
        bus(1'b0, 32'(REG_CUTS), 32'h0, q);
        chk(32'(q != 32'h0), 32'h1, "cuts counted");
        bus(1'b1, 32'(REG_CUTS), 32'h0, q);
        req <= 5'h05;
        repeat (8) @(posedge hclk);
        req <= 5'h00;
        @(posedge hclk);
        @(negedge hclk);
        chk(32'(cmd), 32'h0000_0001, "hold direction");
        n = 1;
        while (cmd[0] === 1'b1 && n < 60) begin
            @(posedge hclk);
            @(negedge hclk);
            n++;
        end
        chk(32'(n >= 20 && n < 60), 32'h1, "hold length");
        chk(32'(stopped), 32'h1, "stopped flag");
        bus(1'b0, 32'h0000_0010, 32'h0, q);
        chk(q, 32'h0000_0001, "ctrl alias");
        bus(1'b0, 32'(REG_CUTS), 32'h0, q);
        chk(q, 32'h0000_0000, "cuts cleared");
        $display("test zero speed done");
        summarize();
    end
    initial begin : watchdog
        #20000;
        n_fail++;
        summarize();
    end
endmodule : llsi_top_tb
